// File: shared/xfer_defines.svh
// Constants for the load/store transfer decoder: register offsets,
// instruction field positions and the pipeline correction.
// Assumes inclusion by bare name from any design or bench file.
`ifndef XFER_DEFINES_SVH
`define XFER_DEFINES_SVH

// APB register byte offsets.
`define OFF_INSTR    8'h00
`define OFF_FLAGS    8'h04
`define OFF_BASE     8'h08
`define OFF_INDEX    8'h0c
`define OFF_LDATA    8'h10
`define OFF_STATUS   8'h14
`define OFF_ADDR     8'h18
`define OFF_WBVAL    8'h1c
`define OFF_RESULT   8'h20
`define OFF_REGS     8'h24
`define OFF_PC       8'h28

// Instruction field positions.
`define COND_HI      31
`define COND_LO      28
`define BIT_P        24
`define BIT_U        23
`define BIT_B        22
`define BIT_IMM      22
`define BIT_W        21
`define BIT_L        20
`define BASE_HI      19
`define BASE_LO      16
`define DEST_HI      15
`define DEST_LO      12
`define BIT_S        6
`define BIT_H        5

// Pipeline correction applied when the program counter is the base.
`define PC_AHEAD     32'h0000_0008
// Index of the program counter in the register file.
`define PC_INDEX     4'hf

// Status register bit positions.
`define ST_EXEC      0
`define ST_LOAD      1
`define ST_WB        2
`define ST_ILLEGAL   3
`define ST_KIND_LO   4
`define ST_KIND_HI   6

`endif

// File: shared/xfer_pkg.sv
// Types used by the transfer decoder; the bench checks their raw codes.
// Assumes nothing beyond a SystemVerilog compiler.
package xfer_pkg;

  // Kind of memory transfer selected by the decoded instruction.
  typedef enum logic [2:0] {
    kind_none,
    kind_load_unsigned_half,
    kind_load_sign_ext_byte,
    kind_load_sign_ext_half,
    kind_word,
    kind_ubyte,
    kind_store_half
  } xfer_kind_e;

endpackage

// File: verilog/cond_check.sv
// Condition field evaluator for the transfer decoder.
// Assumes flags arrive as n, z, c, v from the same clock domain.
module cond_check (
  // Condition code and flags.
  input  wire logic [3:0] cond,
  input  wire logic [3:0] flags,
  // Result.
  output logic            pass
);

  logic n, z, c, v;

  // Unpack the flags in their customary order.
  assign n = flags[3];
  assign z = flags[2];
  assign c = flags[1];
  assign v = flags[0];

  // Code 4'hf never passes, so a reserved encoding does no harm.
  always_comb begin
    unique case (cond)
      4'h0: pass = z;
      4'h1: pass = !z;
      4'h2: pass = c;
      4'h3: pass = !c;
      4'h4: pass = n;
      4'h5: pass = !n;
      4'h6: pass = v;
      4'h7: pass = !v;
      4'h8: pass = c && !z;
      4'h9: pass = !c || z;
      4'ha: pass = (n == v);
      4'hb: pass = (n != v);
      4'hc: pass = !z && (n == v);
      4'hd: pass = z || (n != v);
      4'he: pass = 1'b1;
      4'hf: pass = 1'b0;
    endcase
  end

endmodule

// File: verilog/halfword_signed_transfer_decode.sv
// Decoder and address generator for halfword, signed and word/byte
// load/store instructions, with an APB register front end.
// Assumes software writes operands before the instruction word and
// that a memory system consumes the transfer strobe outputs.
`include "xfer_defines.svh"

module halfword_signed_transfer_decode (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Transfer request towards memory.
  output logic             xfer_req,
  output logic             xfer_we,
  output logic      [1:0]  xfer_size,
  output logic      [31:0] xfer_addr
);

  // Software visible state, plus the internal decode arm flag go_q.
  logic [31:0] instr_q;
  logic [3:0]  flags_q;
  logic [31:0] base_q;
  logic [31:0] index_q;
  logic [31:0] ldata_q;
  logic [31:0] pc_q;
  logic        go_q;

  // Decode results captured after each instruction write.
  logic [7:0]  status_q;
  logic [31:0] addr_q;
  logic [31:0] wbval_q;
  logic [31:0] result_q;
  logic [11:0] regs_q;
  logic        req_q;
  logic        we_q;
  logic [1:0]  size_q;

  // Combinational decode.
  logic                    cond_pass;
  logic                    is_half;
  logic                    is_word;
  logic                    illegal;
  logic                    pre;
  logic                    up;
  logic                    wb;
  logic                    load;
  logic [3:0]              rd;
  logic [3:0]              rn;
  logic [3:0]              rm;
  logic [31:0]             base_eff;
  logic [31:0]             offset;
  logic [31:0]             sum;
  logic [31:0]             addr;
  logic [31:0]             result;
  logic [1:0]              size;
  xfer_pkg::xfer_kind_e    kind;

  // APB access strobes.
  logic wr_en;
  logic rd_en;
  logic mapped;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // The slave never stalls, so every access ends in its first access cycle.
  assign pready = 1'b1;

  // Address decode; any other word address reports an error.
  always_comb begin
    unique case (paddr)
      `OFF_INSTR, `OFF_FLAGS, `OFF_BASE, `OFF_INDEX,
      `OFF_LDATA, `OFF_STATUS, `OFF_ADDR, `OFF_WBVAL,
      `OFF_RESULT, `OFF_REGS, `OFF_PC: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // Condition evaluation against the current flags.
  cond_check u_cond (
    .cond  (instr_q[`COND_HI:`COND_LO]),
    .flags (flags_q),
    .pass  (cond_pass)
  );

  // Register fields at their fixed positions.
  assign rd = instr_q[`DEST_HI:`DEST_LO];
  assign rn = instr_q[`BASE_HI:`BASE_LO];
  assign rm = instr_q[3:0];

  // Addressing control bits shared by both instruction classes.
  assign pre  = instr_q[`BIT_P];
  assign up   = instr_q[`BIT_U];
  assign load = instr_q[`BIT_L];

  // Class detection; a zero signed/half pair is the swap encoding.
  assign is_half = (instr_q[27:25] == 3'h0) && instr_q[7] && instr_q[4]
                   && (instr_q[`BIT_S:`BIT_H] != 2'h0);
  assign is_word = (instr_q[27:26] == 2'h1)
                   && !(instr_q[25] && instr_q[4]);

  // Shift of the index register for the word/byte class.
  function automatic logic [31:0] shift_index(input logic [31:0] val,
                                              input logic [1:0]  typ,
                                              input logic [4:0]  amt);
    logic [63:0] rot;
    rot = {val, val} >> amt;
    unique case (typ)
      2'h0: shift_index = val << amt;
      2'h1: shift_index = val >> amt;
      2'h2: shift_index = $signed(val) >>> amt;
      2'h3: shift_index = rot[31:0];
    endcase
  endfunction

  // The program counter reads eight bytes ahead of the instruction.
  assign base_eff = (rn == `PC_INDEX) ? pc_q + `PC_AHEAD : base_q;

  // Offset selection for both classes.
  always_comb begin
    offset = 32'h0000_0000;
    if (is_half) begin
      if (instr_q[`BIT_IMM]) begin
        offset = {24'h00_0000, instr_q[11:8], instr_q[3:0]};
      end else begin
        offset = index_q;
      end
    end else if (instr_q[25]) begin
      offset = shift_index(index_q, instr_q[6:5], instr_q[11:7]);
    end else begin
      offset = {20'h0_0000, instr_q[11:0]};
    end
  end

  // Up adds, down subtracts; the sum is the modified base.
  assign sum = up ? base_eff + offset : base_eff - offset;
  // Pre-indexing uses the sum, post-indexing the unmodified base.
  assign addr = pre ? sum : base_eff;
  // Post-indexed forms always write the modified base back.
  assign wb = !pre || instr_q[`BIT_W];

  // A nonzero high nibble in the register form is not this instruction.
  assign illegal = !(is_half || is_word)
                   || (is_half && !instr_q[`BIT_IMM]
                       && (instr_q[11:8] != 4'h0));

  // Transfer kind from the signed and half bits or the byte bit.
  always_comb begin
    kind = xfer_pkg::kind_none;
    if (is_half) begin
      unique case (instr_q[`BIT_S:`BIT_H])
        2'h1: kind = load ? xfer_pkg::kind_load_unsigned_half
                          : xfer_pkg::kind_store_half;
        2'h2: kind = xfer_pkg::kind_load_sign_ext_byte;
        2'h3: kind = xfer_pkg::kind_load_sign_ext_half;
        default: kind = xfer_pkg::kind_none;
      endcase
    end else if (is_word) begin
      kind = instr_q[`BIT_B] ? xfer_pkg::kind_ubyte : xfer_pkg::kind_word;
    end
  end

  // Bus size: 0 byte, 1 halfword, 2 word.
  always_comb begin
    unique case (kind)
      xfer_pkg::kind_load_sign_ext_byte,
      xfer_pkg::kind_ubyte: size = 2'h0;
      xfer_pkg::kind_word,
      xfer_pkg::kind_none: size = 2'h2;
      default: size = 2'h1;
    endcase
  end

  // Load data extension into the full destination width.
  always_comb begin
    unique case (kind)
      xfer_pkg::kind_load_unsigned_half:
        result = {16'h0000, ldata_q[15:0]};
      xfer_pkg::kind_load_sign_ext_byte:
        result = {{24{ldata_q[7]}}, ldata_q[7:0]};
      xfer_pkg::kind_load_sign_ext_half:
        result = {{16{ldata_q[15]}}, ldata_q[15:0]};
      xfer_pkg::kind_ubyte:
        result = {24'h00_0000, ldata_q[7:0]};
      xfer_pkg::kind_word:
        result = ldata_q;
      default:
        result = 32'h0000_0000;
    endcase
  end

  // Instruction register; a write also arms one decode cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= 32'h0000_0000;
      go_q    <= 1'b0;
    end else begin
      go_q <= wr_en && (paddr == `OFF_INSTR);
      if (wr_en && (paddr == `OFF_INSTR)) begin
        instr_q <= pwdata;
      end
    end
  end

  // Operand registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 4'h0;
      base_q  <= 32'h0000_0000;
      index_q <= 32'h0000_0000;
      ldata_q <= 32'h0000_0000;
      pc_q    <= 32'h0000_0000;
    end else if (wr_en) begin
      unique case (paddr)
        `OFF_FLAGS: flags_q <= pwdata[3:0];
        `OFF_BASE:  base_q  <= pwdata;
        `OFF_INDEX: index_q <= pwdata;
        `OFF_LDATA: ldata_q <= pwdata;
        `OFF_PC:    pc_q    <= pwdata;
        default: ;
      endcase
    end
  end

  // Capture the decode one cycle after the instruction is written.
  // A failed condition leaves the base untouched and issues no request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 8'h00;
      addr_q   <= 32'h0000_0000;
      wbval_q  <= 32'h0000_0000;
      result_q <= 32'h0000_0000;
      regs_q   <= 12'h000;
    end else if (go_q) begin
      status_q                          <= 8'h00;
      status_q[`ST_EXEC]                <= cond_pass && !illegal;
      status_q[`ST_LOAD]                <= load;
      status_q[`ST_WB]                  <= cond_pass && !illegal && wb;
      status_q[`ST_ILLEGAL]             <= illegal;
      status_q[`ST_KIND_HI:`ST_KIND_LO] <= kind;
      addr_q   <= addr;
      // Base keeps its old value when no write-back happens.
      wbval_q  <= (cond_pass && !illegal && wb) ? sum : base_eff;
      result_q <= (cond_pass && !illegal && load) ? result : 32'h0000_0000;
      regs_q   <= {rm, rn, rd};
    end
  end

  // Transfer request pulse towards memory with its attributes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q  <= 1'b0;
      we_q   <= 1'b0;
      size_q <= 2'h0;
    end else begin
      req_q <= go_q && cond_pass && !illegal;
      if (go_q) begin
        we_q   <= !load;
        size_q <= size;
      end
    end
  end

  assign xfer_req  = req_q;
  assign xfer_we   = we_q;
  assign xfer_size = size_q;
  assign xfer_addr = addr_q;

  // Read data multiplexer; unmapped reads return zero.
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        `OFF_INSTR:  prdata = instr_q;
        `OFF_FLAGS:  prdata = {28'h000_0000, flags_q};
        `OFF_BASE:   prdata = base_q;
        `OFF_INDEX:  prdata = index_q;
        `OFF_LDATA:  prdata = ldata_q;
        `OFF_STATUS: prdata = {24'h00_0000, status_q};
        `OFF_ADDR:   prdata = addr_q;
        `OFF_WBVAL:  prdata = wbval_q;
        `OFF_RESULT: prdata = result_q;
        `OFF_REGS:   prdata = {20'h0_0000, regs_q};
        `OFF_PC:     prdata = pc_q;
        default:     prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: test/xfer_checker_properties.sv
// Checker for the decoder's bus answers and transfer request outputs.
// Assumes it is bound to the decoder's top module and sees its ports.
`include "xfer_defines.svh"

module xfer_checker (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Transfer request.
  input wire logic        xfer_req,
  input wire logic        xfer_we,
  input wire logic [1:0]  xfer_size,
  input wire logic [31:0] xfer_addr
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A decode is launched only by a taken write to the instruction word.
  logic go;
  assign go = psel && penable && pwrite && paddr == `OFF_INSTR;

  AST_REQ_CAUSE: assert property (xfer_req |-> $past(go) || $past(go, 2))
    else $error("request without instruction write");
  AST_REQ_PULSE: assert property (xfer_req |=> !xfer_req)
    else $error("request longer than one cycle");
  AST_ADDR_HOLD: assert property ($changed(xfer_addr) |-> $past(go) || $past(go, 2))
    else $error("address moved without a decode");
  AST_DIR_HOLD: assert property ($changed(xfer_we) |-> $past(go) || $past(go, 2))
    else $error("direction moved without a decode");
  AST_SIZE_CODE: assert property (xfer_size != 2'h3)
    else $error("undefined transfer size");
  AST_READY_NOW: assert property (psel && penable |-> pready)
    else $error("bus access stalled");
  AST_ERR_MAP: assert property (psel && penable && paddr > `OFF_PC |-> pslverr)
    else $error("unmapped access not flagged");
  AST_ERR_ONLY: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  AST_RDATA_IDLE: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read access");
endmodule

bind halfword_signed_transfer_decode xfer_checker chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .xfer_req, .xfer_we, .xfer_size, .xfer_addr
);

// File: test/mem_model.sv
// Memory side model that logs every transfer request it is handed.
// Assumes the request strobe and its qualifiers come from one clock.
module mem_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Transfer request.
  input  wire logic        xfer_req,
  input  wire logic        xfer_we,
  input  wire logic [1:0]  xfer_size,
  input  wire logic [31:0] xfer_addr,
  // Log for the bench.
  output logic      [7:0]  n_req,
  output logic      [31:0] last_addr,
  output logic      [3:0]  last_ctl
);
  timeunit 1ns;
  timeprecision 100ps;

  // Qualifiers are taken only with the strobe, as a real memory would.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_req     <= 8'h00;
      last_addr <= 32'h0;
      last_ctl  <= 4'h0;
    end else if (xfer_req) begin
      n_req     <= n_req + 8'h01;
      last_addr <= xfer_addr;
      last_ctl  <= {1'b0, xfer_we, xfer_size};
    end
  end
endmodule

// File: test/halfword_signed_transfer_decode_bench.sv
// Self-checking bench: decodes instruction words through the bus.
// Assumes the decoder, the memory model and the bound checker.
`include "xfer_defines.svh"

module halfword_signed_transfer_decode_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        xfer_req, xfer_we, err;
  logic [1:0]  xfer_size;
  logic [3:0]  last_ctl;
  logic [7:0]  paddr, n_req;
  logic [31:0] pwdata, prdata, xfer_addr, last_addr, rdat;
  int          miscompares = 0;
  int          n_checks = 0;

  halfword_signed_transfer_decode DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .xfer_req, .xfer_we, .xfer_size, .xfer_addr);
  mem_model mem (.pclk, .presetn, .xfer_req, .xfer_we, .xfer_size, .xfer_addr,
    .n_req, .last_addr, .last_ctl);

  // Free-running clock at 4 ns.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One bus transfer; an idle cycle follows so strobes are never re-driven at once.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // Only a missing answer is a timeout, even if it arrives on the last try.
    if (pready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] hw(input logic [3:0] c, input logic [4:0] f,
      input logic [3:0] rn, hi, input logic [1:0] sh, input logic [3:0] lo);
    hw = {c, 3'h0, f, rn, 4'h1, hi, 1'b1, sh, 1'b1, lo};
  endfunction

  function automatic logic [31:0] wd(input logic [3:0] c, input logic [5:0] f,
      input logic [3:0] rn, input logic [11:0] off);
    wd = {c, 2'h1, f, rn, 4'h1, off};
  endfunction

  // Expected {we, size} from the expected status kind.
  function automatic logic [31:0] ctl(input logic [7:0] s);
    case (s[6:4])
      3'h4: ctl = {29'h0, ~s[1], 2'h2};
      3'h2, 3'h5: ctl = {29'h0, ~s[1], 2'h0};
      default: ctl = {29'h0, ~s[1], 2'h1};
    endcase
  endfunction

  // Loads operands, issues the instruction, then checks results and the memory side.
  task automatic run(input logic [31:0] ins, b, x, ld, input logic [3:0] fl,
      input logic [7:0] m, s, input logic [31:0] ad, wb, res);
    logic [7:0] n0;
    n0 = n_req;
    apb(1'b1, `OFF_FLAGS, {28'h0, fl});
    apb(1'b1, `OFF_BASE, b);
    apb(1'b1, `OFF_INDEX, x);
    apb(1'b1, `OFF_LDATA, ld);
    apb(1'b1, `OFF_INSTR, ins);
    repeat (2) @(posedge pclk);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rdat & {24'h0, m}, {24'h0, s});
    apb(1'b0, `OFF_WBVAL, 32'h0);
    check(rdat, wb);
    apb(1'b0, `OFF_RESULT, 32'h0);
    check(rdat, res);
    check({24'h0, n_req - n0}, {31'h0, s[0]});
    if (s[0]) begin
      apb(1'b0, `OFF_ADDR, 32'h0);
      check(rdat, ad);
      check(last_addr, ad);
      check({28'h0, last_ctl}, ctl(s));
    end
  endtask

  // Main sequence: reset, bus map, then one decode per addressing case.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFF_STATUS, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    check({31'h0, err}, 32'h1);
    run(hw(4'he, 5'h1a, 4'h2, 4'h0, 2'h1, 4'h4), 32'h1000, 32'h24, 32'h0, 4'h0,
      8'hff, 8'h65, 32'h1024, 32'h1024, 32'h0);
    apb(1'b0, `OFF_REGS, 32'h0);
    check(rdat, 32'h421);
    run(hw(4'he, 5'h08, 4'h2, 4'h0, 2'h1, 4'h4), 32'h1000, 32'h24, 32'h0, 4'h0,
      8'hff, 8'h65, 32'h1000, 32'h1024, 32'h0);
    run(hw(4'he, 5'h1d, 4'h2, 4'h1, 2'h1, 4'h0), 32'h2000, 32'h0, 32'hffff8001, 4'h0,
      8'hff, 8'h13, 32'h2010, 32'h2000, 32'h8001);
    run(hw(4'he, 5'h17, 4'h2, 4'ha, 2'h2, 4'h5), 32'h3000, 32'h0, 32'h80, 4'h0,
      8'hff, 8'h27, 32'h2f5b, 32'h2f5b, 32'hffffff80);
    run(hw(4'he, 5'h01, 4'h2, 4'h0, 2'h3, 4'h4), 32'h4000, 32'h10, 32'h18000, 4'h0,
      8'hff, 8'h37, 32'h4000, 32'h3ff0, 32'hffff8000);
    run(wd(4'h0, 6'h1d, 4'h6, 12'h005), 32'h5000, 32'h0, 32'habcdef99, 4'h0,
      8'h05, 8'h00, 32'h0, 32'h5000, 32'h0);
    run(wd(4'h0, 6'h1d, 4'h6, 12'h005), 32'h5000, 32'h0, 32'habcdef99, 4'h4,
      8'hff, 8'h53, 32'h5005, 32'h5000, 32'h99);
    // Reserved condition code never executes, whatever the flags.
    run(wd(4'hf, 6'h1d, 4'h6, 12'h005), 32'h5000, 32'h0, 32'habcdef99, 4'hf,
      8'h05, 8'h00, 32'h0, 32'h5000, 32'h0);
    // Signed less-than passes when negative and overflow differ.
    run(wd(4'hb, 6'h1d, 4'h6, 12'h005), 32'h5000, 32'h0, 32'habcdef99, 4'h8,
      8'hff, 8'h53, 32'h5005, 32'h5000, 32'h99);
    run(wd(4'he, 6'h39, 4'h2, 12'h103), 32'h6000, 32'h3, 32'h11223344, 4'h0,
      8'hff, 8'h43, 32'h600c, 32'h6000, 32'h11223344);
    // Arithmetic right shift by four keeps the sign of the index.
    run(wd(4'he, 6'h39, 4'h2, 12'h243), 32'h6000, 32'h80000000, 32'h5, 4'h0,
      8'hff, 8'h43, 32'hf8006000, 32'h6000, 32'h5);
    run(hw(4'he, 5'h19, 4'h2, 4'h1, 2'h1, 4'h4), 32'h1000, 32'h0, 32'h0, 4'h0,
      8'h0d, 8'h08, 32'h0, 32'h1000, 32'h0);
    run(hw(4'he, 5'h1d, 4'h2, 4'h0, 2'h0, 4'h0), 32'h1000, 32'h0, 32'h0, 4'h0,
      8'h0d, 8'h08, 32'h0, 32'h1000, 32'h0);
    apb(1'b1, `OFF_PC, 32'h100);
    run(wd(4'he, 6'h18, 4'hf, 12'h010), 32'h0, 32'h0, 32'h0, 4'h0,
      8'hff, 8'h41, 32'h118, 32'h108, 32'h0);
    end_of_test();
  end
endmodule
